// ### hdl/fcs_host.sv
// Host controller that sequences erase, suspend, resume and program cycles to a flash
// Summary of operation
// [RULE1] Erase write three: setup 80h at 555h
// [RULE2] Erase write six: confirm code 10h
// [RULE3] Bad unlock or confirm aborts to read
// [RULE4] Device preprograms zeros before erasing itself
// [RULE5] Reads after sixth write return status
// [RULE6] Polling bit zero busy, one done
// [RULE7] Both toggle bits stop when finished
// [RULE8] Failure flag one marks failed erase
// [RULE9] Pause is single write, no unlock
// [RULE10] Pause honoured only during block erase; the code pauses its chip erase
// [RULE11] Pause during timeout ends timeout too
// [RULE12] Toggles stop within 15 us of pause
// [RULE13] Paused block reads toggle; others valid
// [RULE14] Paused device takes only continue, program
// [RULE15] Paused programming only outside erased blocks; the code sends program while paused to any user_addr
// [RULE16] Return-to-read while paused kills erase
// [RULE17] Continue is single 30h write, no unlock
// [RULE18] Power-up puts device in read mode
// [RULE19] Host holds strobes high during power-up
// [RULE20] Writes blocked below lockout level
// [RULE21] Address on strobe fall, data on rise
// [RULE22] Running erase takes only pause, reset
// [RULE23] After failure host issues return-to-read
// [RULE24] Wrong address/data pair is bad unlock
`include "fcs_cfg.svh"
module fcs_host
#(
  parameter int POWER_CYC = `FCS_VCS_CYC, // Supply settle time before first write
  parameter logic [7:0] SUSPEND_CODE = 8'h00, // Erase pause code, set for the part used
  parameter logic [7:0] PROGRAM_CODE = 8'h00, // Byte program code, set for the part used
  parameter logic [7:0] RESET_CODE = 8'h00 // Return-to-read code, set for the part used
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [17:0] flash_addr,
  input wire logic [7:0] flash_dq_in,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n
);
  import fcs_pkg::*;

  fcs_state_t state; // Pin phase
  logic [15:0] cnt; // Phase timer
  fcs_op_t op; // Operation under way
  logic [2:0] step; // Write index inside a sequence
  logic [17:0] user_addr; // Software target address
  logic [7:0] user_data; // Software program data
  logic [7:0] rdata; // Last byte read from the flash
  logic [7:0] dq_s1, dq_s2; // Two-stage sync of the data pins
  logic [7:0] prev; // Previous poll sample
  logic have_prev; // Prev holds a sample of this poll
  logic fail_seen; // Failure flag seen once while toggling
  logic polling; // Reads are status polls
  logic susp_pend; // Pause requested during an erase poll
  logic busy, done, fail, erasing, suspended, refused;

  // Number of writes in each operation
  function automatic logic [2:0] seq_len(input fcs_op_t o);
    case (o)
      `FCS_OP_ERASE: seq_len = 3'd6;
      `FCS_OP_PROGRAM: seq_len = 3'd4;
      default: seq_len = 3'd1;
    endcase
  endfunction

  // Address and data of write idx; both unlock pairs share one slot pattern
  function automatic logic [25:0] seq_word(input fcs_op_t o, input logic [2:0] idx);
    logic [2:0] k;
    k = (o == `FCS_OP_ERASE && idx > 3'd2) ? idx - 3'd3 : idx;
    if (seq_len(o) == 3'd1)
      seq_word = {user_addr, o == `FCS_OP_SUSPEND ? SUSPEND_CODE : // [RULE9]
                  o == `FCS_OP_RESUME ? `FCS_ERASE_CONTINUE : RESET_CODE}; // [RULE17]
    else if (k == 3'd0)
      seq_word = {`FCS_UNLOCK1_ADDR, `FCS_UNLOCK1_DATA}; // [RULE24] [RULE3]
    else if (k == 3'd1)
      seq_word = {`FCS_UNLOCK2_ADDR, `FCS_UNLOCK2_DATA}; // [RULE24] [RULE3]
    else if (o == `FCS_OP_PROGRAM && idx == 3'd3)
      seq_word = {user_addr, user_data}; // Software keeps it outside the erase [RULE15]
    else if (o == `FCS_OP_PROGRAM)
      seq_word = {`FCS_SETUP_ADDR, PROGRAM_CODE};
    else if (idx == 3'd2)
      seq_word = {`FCS_SETUP_ADDR, `FCS_ERASE_SETUP}; // [RULE1]
    else
      seq_word = {`FCS_SETUP_ADDR, `FCS_ERASE_CONFIRM}; // [RULE2]
  endfunction

  // Register decode
  wire logic cmd_wr = reg_wr && reg_addr == `FCS_REG_CMD;
  wire fcs_op_t cmd_op = reg_wdata[2:0];
  wire logic [25:0] word = seq_word(op, step);
  // Paused: only continue, program, read and return-to-read are sent
  wire logic ok_susp = cmd_op == `FCS_OP_RESUME || cmd_op == `FCS_OP_PROGRAM ||
                       cmd_op == `FCS_OP_READ || cmd_op == `FCS_OP_RESET; // [RULE14]
  // Idle: pause is never started from here, continue only when paused
  wire logic ok_idle = suspended ? ok_susp :
                       (cmd_op == `FCS_OP_READ || cmd_op == `FCS_OP_ERASE ||
                        cmd_op == `FCS_OP_PROGRAM || cmd_op == `FCS_OP_RESET); // [RULE10]
  wire logic start = cmd_wr && !busy && state == FCS_IDLE && ok_idle;
  // While the erase runs only a pause is queued from software
  wire logic pend = cmd_wr && busy && polling && erasing && !suspended &&
                    cmd_op == `FCS_OP_SUSPEND; // [RULE22]
  wire logic reject = cmd_wr && !start && !pend;
  wire logic [7:0] smp = dq_s2;
  wire logic toggling = have_prev &&
                        smp[`FCS_TOGGLE_BIT_MAIN] != prev[`FCS_TOGGLE_BIT_MAIN]; // [RULE7]
  wire logic settled = have_prev && !toggling;
  wire logic [31:0] status = {26'h0, refused, suspended, erasing, fail, done, busy};
  wire logic [31:0] rd_mux = reg_addr == `FCS_REG_STATUS ? status :
                             reg_addr == `FCS_REG_RDATA ? {24'h0, rdata} :
                             reg_addr == `FCS_REG_ADDR ? {14'h0, user_addr} :
                             reg_addr == `FCS_REG_DATA ? {24'h0, user_data} : 32'h0;
  // Data pins cross into the clock domain through two flops
  always_ff @(posedge clk_sys) begin
    dq_s1 <= flash_dq_in;
    dq_s2 <= dq_s1;
  end
  // Read data one cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end
  // Software-written operands
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      user_addr <= 18'h0;
      user_data <= 8'h0;
    end else if (reg_wr && reg_addr == `FCS_REG_ADDR) begin
      user_addr <= reg_wdata[17:0];
    end else if (reg_wr && reg_addr == `FCS_REG_DATA) begin
      user_data <= reg_wdata[7:0];
    end
  end

  // Pin sequencer: writes are write-strobe controlled, reads are output-enable reads
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state <= FCS_POWER;
      cnt <= 16'h0;
      op <= `FCS_OP_READ;
      step <= 3'h0;
      flash_addr <= 18'h0;
      flash_dq_out <= 8'h0;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1; // Strobes high through power-up [RULE19]
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      rdata <= 8'h0;
      prev <= 8'h0;
      have_prev <= 1'b0;
      fail_seen <= 1'b0;
      polling <= 1'b0;
      susp_pend <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      erasing <= 1'b0;
      suspended <= 1'b0;
      refused <= 1'b0;
    end else begin
      cnt <= cnt + 16'h1;
      if (pend) susp_pend <= 1'b1;
      if (cmd_wr) refused <= reject; // An untaken command leaves a mark
      case (state)
        // Wait for the supply to settle; device wakes in read mode [RULE18]
        FCS_POWER: if (cnt >= 16'(POWER_CYC - 1)) state <= FCS_IDLE; // [RULE20]
        FCS_IDLE: begin
          flash_ce_n <= 1'b1;
          if (start) begin
            op <= cmd_op;
            step <= 3'h0;
            busy <= 1'b1;
            done <= 1'b0;
            fail <= 1'b0;
            have_prev <= 1'b0;
            fail_seen <= 1'b0;
            polling <= cmd_op == `FCS_OP_READ;
            cnt <= 16'h0;
            state <= cmd_op == `FCS_OP_READ ? FCS_R_WAIT : FCS_W_SETUP;
            flash_ce_n <= 1'b0;
            flash_oe_n <= cmd_op != `FCS_OP_READ;
            flash_addr <= user_addr;
          end
        end
        // Address and data settle before the write strobe falls [RULE21]
        FCS_W_SETUP: begin
          flash_ce_n <= 1'b0;
          flash_oe_n <= 1'b1;
          flash_addr <= word[25:8];
          flash_dq_out <= word[7:0];
          flash_dq_oe <= 1'b1;
          if (cnt >= 16'(`FCS_AS_CYC)) begin
            flash_we_n <= 1'b0;
            cnt <= 16'h0;
            state <= FCS_W_LOW;
          end
        end
        // Data stays put until after the rising edge latches it [RULE21]
        FCS_W_LOW: begin
          if (cnt >= 16'(`FCS_WP_CYC - 1)) begin
            flash_we_n <= 1'b1;
            cnt <= 16'h0;
            state <= FCS_W_HIGH;
          end
        end
        FCS_W_HIGH: begin
          if (cnt >= 16'(`FCS_WPH_CYC - 1)) begin
            flash_dq_oe <= 1'b0;
            cnt <= 16'h0;
            if (step != seq_len(op) - 3'h1) begin
              step <= step + 3'h1;
              state <= FCS_W_SETUP;
            end else if (op == `FCS_OP_RESET) begin
              // Return-to-read drops an erase, paused or failed [RULE16] [RULE23]
              erasing <= 1'b0;
              suspended <= 1'b0;
              busy <= 1'b0;
              done <= 1'b1;
              flash_ce_n <= 1'b1;
              state <= FCS_IDLE;
            end else begin
              // Last write edge of the sequence passed: reads now return status [RULE5]
              if (op == `FCS_OP_ERASE || op == `FCS_OP_RESUME) erasing <= 1'b1;
              if (op == `FCS_OP_RESUME) suspended <= 1'b0;
              polling <= 1'b1;
              have_prev <= 1'b0;
              flash_oe_n <= 1'b0;
              state <= FCS_R_WAIT;
            end
          end
        end
        // Output enable low for access plus sync; high in cycle 0 so each poll is a new read
        FCS_R_WAIT: begin
          if (cnt != 16'h0) flash_oe_n <= 1'b0;
          if (cnt >= 16'(`FCS_ACC_CYC + 2)) state <= FCS_R_DONE;
        end
        FCS_R_DONE: begin
          flash_oe_n <= 1'b1;
          rdata <= smp;
          prev <= smp;
          have_prev <= 1'b1;
          cnt <= 16'h0;
          if (op == `FCS_OP_READ) begin
            busy <= 1'b0;
            done <= 1'b1;
            flash_ce_n <= 1'b1;
            state <= FCS_IDLE;
          end else if (susp_pend && erasing) begin
            // A pause may land in the timeout window; the device ends it too [RULE11]
            susp_pend <= 1'b0;
            op <= `FCS_OP_SUSPEND;
            step <= 3'h0;
            state <= FCS_W_SETUP;
          end else if (settled && smp[`FCS_POLLING_BIT]) begin
            // Toggle stopped and polling bit high: finished [RULE6] [RULE7] [RULE12]
            if (op == `FCS_OP_SUSPEND) suspended <= 1'b1; // [RULE13]
            if (op == `FCS_OP_ERASE || op == `FCS_OP_RESUME) erasing <= 1'b0; // [RULE4]
            busy <= 1'b0;
            done <= 1'b1;
            flash_ce_n <= 1'b1;
            state <= FCS_IDLE;
          end else if (settled && op == `FCS_OP_SUSPEND) begin
            // Paused: toggles stopped though the erase is not complete [RULE12]
            suspended <= 1'b1;
            busy <= 1'b0;
            done <= 1'b1;
            flash_ce_n <= 1'b1;
            state <= FCS_IDLE;
          end else if (toggling && smp[`FCS_FAILURE_FLAG] && fail_seen) begin
            // Still toggling after a second look at the failure flag [RULE8] [RULE23]
            fail <= 1'b1;
            op <= `FCS_OP_RESET;
            step <= 3'h0;
            state <= FCS_W_SETUP;
          end else begin
            // Another poll read; a failure flag is confirmed once more first
            fail_seen <= toggling && smp[`FCS_FAILURE_FLAG];
            state <= FCS_R_WAIT;
          end
        end
        default: state <= FCS_IDLE;
      endcase
    end
  end
endmodule

// ### hdl/fcs_cfg.svh
// Constants for the flash command sequencer host controller
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH
// Software register byte offsets
`define FCS_REG_CMD 8'h00
`define FCS_REG_ADDR 8'h04
`define FCS_REG_DATA 8'h08
`define FCS_REG_STATUS 8'h0c
`define FCS_REG_RDATA 8'h10
// Operation codes in the command register, low three bits
`define FCS_OP_READ 3'h1
`define FCS_OP_ERASE 3'h2
`define FCS_OP_SUSPEND 3'h3
`define FCS_OP_RESUME 3'h4
`define FCS_OP_PROGRAM 3'h5
`define FCS_OP_RESET 3'h6
// Status bit positions
`define FCS_ST_BUSY 0
`define FCS_ST_DONE 1
`define FCS_ST_FAIL 2
`define FCS_ST_ERASING 3
`define FCS_ST_SUSPENDED 4
`define FCS_ST_REFUSED 5
// Flash command words
`define FCS_UNLOCK1_ADDR 18'h00555
`define FCS_UNLOCK1_DATA 8'haa
`define FCS_UNLOCK2_ADDR 18'h002aa
`define FCS_UNLOCK2_DATA 8'h55
`define FCS_SETUP_ADDR 18'h00555
`define FCS_ERASE_SETUP 8'h80
`define FCS_ERASE_CONFIRM 8'h10
`define FCS_ERASE_CONTINUE 8'h30
// Status bit positions inside a flash read
`define FCS_POLLING_BIT 7
`define FCS_TOGGLE_BIT_MAIN 6
`define FCS_FAILURE_FLAG 5
// Pin timing in ns or us and derived cycle counts
`define FCS_CLK_NS 10
`define FCS_T_AS_NS 5
`define FCS_T_WP_NS 35
`define FCS_T_WPH_NS 20
`define FCS_T_ACC_NS 70
`define FCS_T_VCS_US 50
`define FCS_AS_CYC ((`FCS_T_AS_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_WP_CYC ((`FCS_T_WP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_WPH_CYC ((`FCS_T_WPH_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_ACC_CYC ((`FCS_T_ACC_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_VCS_CYC ((`FCS_T_VCS_US * 1000 + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`endif

// ### hdl/fcs_pkg.sv
// Types for the flash command sequencer host controller
package fcs_pkg;
  // Pin-level phases of the controller
  typedef enum logic [2:0] {
    FCS_POWER, FCS_IDLE, FCS_W_SETUP, FCS_W_LOW, FCS_W_HIGH, FCS_R_WAIT, FCS_R_DONE
  } fcs_state_t;
  typedef logic [2:0] fcs_op_t;
endpackage

// ### testbench/fcs_host_properties.sv
// Port-level checks on the flash host controller
module fcs_host_properties #(
  parameter int POWER_CYC = 8 // Supply settle cycles, as in the design
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [17:0] flash_addr,
  input wire logic [7:0] flash_dq_in,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n
);
  int up_cnt; // Cycles since reset release; saturates so it never wraps
  // Settle counter
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      up_cnt <= 0;
    end else if (up_cnt <= POWER_CYC) begin
      up_cnt <= up_cnt + 1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  a_power_quiet: assert property (up_cnt < POWER_CYC |-> flash_ce_n && flash_we_n)
    else $error("flash strobe active while supply settles");
  a_we_with_ce: assert property (!flash_we_n |-> !flash_ce_n)
    else $error("write strobe low without chip enable");
  a_we_low_len: assert property ($fell(flash_we_n) |-> !flash_we_n [*4] ##1 flash_we_n)
    else $error("write strobe low phase not four cycles");
  a_we_high_gap: assert property ($rose(flash_we_n) |-> flash_we_n [*2])
    else $error("write strobe high phase too short");
  a_addr_hold: assert property (!flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved during write strobe");
  a_dq_driven: assert property (!flash_we_n |-> flash_dq_oe)
    else $error("data pins not driven during write");
  a_no_clash: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
    else $error("host drives data pins during a read");
  a_setup_addr: assert property ($rose(flash_we_n) && flash_dq_out == 8'h80
    |-> flash_addr == 18'h00555)
    else $error("erase setup code at wrong address");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  c_write: cover property ($fell(flash_we_n));
  c_read: cover property ($fell(flash_oe_n));
  c_confirm: cover property ($rose(flash_we_n) && flash_dq_out == 8'h10);
endmodule

bind fcs_host fcs_host_properties #(.POWER_CYC(POWER_CYC)) u_props (.clk_sys(clk_sys),
  .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_dq_in(flash_dq_in),
  .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
  .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));

// ### testbench/fcs_flash_model.sv
// Behavioural byte-wide flash answering the host controller pins
module fcs_flash_model #(
  parameter logic [7:0] SUSPEND_CODE = 8'h5e, // Arbitrary erase pause code
  parameter logic [7:0] PROGRAM_CODE = 8'h6c, // Arbitrary byte program code
  parameter logic [7:0] RESET_CODE = 8'h7d, // Arbitrary return-to-read code
  parameter int ERASE_READS = 10 // Status reads an erase stays busy
) (
  input wire logic [17:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic fail_mode,
  output logic [7:0] flash_dq_in
);
  logic [7:0] mem [256]; // Low address byte only, keeps the model small
  logic [7:0] rd_val = 8'hff; // Byte driven during a read
  logic [7:0] last = 8'hff; // Last byte driven
  logic [7:0] pd = 8'hff; // Byte being programmed
  logic [17:0] wa = 18'h0; // Address latched at strobe fall
  logic tog = 1'b0; // Toggle state
  int mode = 0; // 0 read, 1 erase, 2 paused, 3 program, 4 failed
  int cyc = 0; // Position in the unlock sequence
  int left = 0; // Busy reads left
  initial foreach (mem[i]) mem[i] = 8'hff;
  // Released bus shows the flipped leftover, so a stale sample cannot pass
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : (!flash_ce_n && !flash_oe_n) ? rd_val : ~last;
  function automatic logic hit(logic [17:0] a, logic [7:0] d, logic [17:0] ea, logic [7:0] ed);
    return a == ea && d == ed;
  endfunction
  // One accepted write; supply is taken as above lockout_level throughout
  task automatic step(input logic [17:0] a, input logic [7:0] d);
    if (mode == 1) begin
      if (d == SUSPEND_CODE) mode = 2;
      else if (d == RESET_CODE) mode = 0;
    end else if (mode == 2) begin
      // Program is ignored: every block is under chip erase
      if (d == 8'h30) mode = 1;
      else if (d == RESET_CODE) begin
        foreach (mem[i]) mem[i] = 8'h5a; // Erase abandoned, contents invalid
        mode = 0;
      end
    end else if (mode == 4) begin
      if (d == RESET_CODE) mode = 0;
    end else if (mode == 0) begin
      case (cyc)
        0: cyc = hit(a, d, 18'h555, 8'haa) ? 1 : 0;
        1: cyc = hit(a, d, 18'h2aa, 8'h55) ? 2 : 0;
        2: cyc = hit(a, d, 18'h555, 8'h80) ? 3 : hit(a, d, 18'h555, PROGRAM_CODE) ? 6 : 0;
        3: cyc = hit(a, d, 18'h555, 8'haa) ? 4 : 0;
        4: cyc = hit(a, d, 18'h2aa, 8'h55) ? 5 : 0;
        5: begin
          if (d == 8'h10) begin
            foreach (mem[i]) mem[i] = 8'h00;
            foreach (mem[i]) mem[i] = 8'hff;
            mode = 1;
            left = ERASE_READS;
          end
          cyc = 0;
        end
        default: begin
          pd = d;
          mem[a[7:0]] = mem[a[7:0]] & d;
          mode = 3;
          left = 2;
          cyc = 0;
        end
      endcase
    end
  endtask
  always @(negedge flash_we_n) if (!flash_ce_n) wa = flash_addr;
  always @(posedge flash_we_n) if (!flash_ce_n) step(wa, flash_dq_out);
  // Read start: status bits while busy, paused or failed, array data in read mode
  always @(negedge flash_oe_n) begin
    if (!flash_ce_n) begin
      tog = ~tog;
      case (mode)
        1, 4: rd_val = {1'b0, tog, mode == 4, 2'b00, tog, 2'b00};
        2: rd_val = {5'b01000, tog, 2'b00};
        3: rd_val = {~pd[7], tog, 3'b000, tog, 2'b00};
        default: rd_val = mem[flash_addr[7:0]];
      endcase
      if ((mode == 1 || mode == 3) && left > 0) left--;
      if (mode == 1 && left == 0) mode = fail_mode ? 4 : 0;
      if (mode == 3 && left == 0) mode = 0;
    end
  end
  always @(posedge flash_oe_n) last = rd_val;
endmodule

// ### testbench/tb_flash_chip_erase_suspend.sv
// Self-checking bench for the flash host controller with its flash model
`include "fcs_cfg.svh"
module tb_flash_chip_erase_suspend;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] SUSP = 8'h5e; // Arbitrary pause code
  localparam logic [7:0] PROG = 8'h6c; // Arbitrary program code
  localparam logic [7:0] RST = 8'h7d; // Arbitrary return-to-read code
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic fail_mode = 1'b0; // Model reports a failed erase
  logic rd_d = 1'b0; // Read data stand this cycle
  logic [31:0] reg_rdata, st;
  logic [17:0] flash_addr, adr;
  logic [7:0] flash_dq_in, flash_dq_out, dat;
  logic flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
  logic [31:0] exp_q[$], msk_q[$]; // Expected read data and masks
  int mismatches = 0;
  int num_checks = 0;
  always #5 clk_sys = ~clk_sys;
  fcs_host #(.POWER_CYC(8), .SUSPEND_CODE(SUSP), .PROGRAM_CODE(PROG), .RESET_CODE(RST)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_dq_in(flash_dq_in),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));
  fcs_flash_model #(.SUSPEND_CODE(SUSP), .PROGRAM_CODE(PROG), .RESET_CODE(RST)) u_flash (
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
    .fail_mode(fail_mode), .flash_dq_in(flash_dq_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One-cycle write strobe; the idle edge after it avoids double assignment
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read with a noted expectation; a zero mask marks an uncompared poll
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 st = reg_rdata;
  endtask
  // Issue a command, poll busy under a bound, then compare status
  task automatic op(input logic [2:0] c, input logic [31:0] e, input logic [31:0] m);
    wr(`FCS_REG_CMD, 32'(c));
    @(posedge clk_sys);
    for (int i = 0; i < 3000; i++) begin
      rd(`FCS_REG_STATUS, 32'h0, 32'h0);
      if (st[`FCS_ST_BUSY] === 1'b0) break;
    end
    rd(`FCS_REG_STATUS, e, m);
  endtask
  // Takes the oldest note whenever read data stand on the bus
  always @(posedge clk_sys) begin
    if (rd_d && msk_q.size() > 0) begin
      if (msk_q[0] != 32'h0) check(reg_rdata & msk_q[0], exp_q[0]);
      void'(msk_q.pop_front());
      void'(exp_q.pop_front());
    end
    rd_d <= reg_rd;
  end
  // Tests take under a thousand cycles; far beyond that is a hang
  initial begin
    #400_000;
    mismatches++;
    end_sim();
  end
  initial begin
    void'($urandom(32'hff68));
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    wr(`FCS_REG_CMD, 32'(`FCS_OP_READ));
    rd(`FCS_REG_STATUS, 32'h20, 32'h21);
    rd(8'h14, 32'h0, 32'hffffffff);
    repeat (12) @(posedge clk_sys);
    adr = 18'($urandom);
    dat = 8'($urandom) | 8'h81; // Bit 7 set keeps data polling plain
    wr(`FCS_REG_ADDR, 32'(adr));
    wr(`FCS_REG_DATA, 32'(dat));
    rd(`FCS_REG_ADDR, 32'(adr), 32'h3ffff);
    rd(`FCS_REG_DATA, 32'(dat), 32'hff);
    op(`FCS_OP_PROGRAM, 32'h2, 32'h7);
    op(`FCS_OP_READ, 32'h2, 32'h7);
    rd(`FCS_REG_RDATA, 32'(dat), 32'hff);
    op(`FCS_OP_ERASE, 32'h2, 32'h7);
    op(`FCS_OP_READ, 32'h2, 32'h7);
    rd(`FCS_REG_RDATA, 32'hff, 32'hff);
    wr(`FCS_REG_CMD, 32'(`FCS_OP_SUSPEND));
    rd(`FCS_REG_STATUS, 32'h20, 32'h21);
    wr(`FCS_REG_CMD, 32'(`FCS_OP_ERASE));
    repeat (90) @(posedge clk_sys);
    op(`FCS_OP_SUSPEND, 32'h12, 32'h17);
    op(`FCS_OP_RESUME, 32'h02, 32'h17);
    fail_mode <= 1'b1;
    op(`FCS_OP_ERASE, 32'h06, 32'h0f);
    fail_mode <= 1'b0;
    op(`FCS_OP_READ, 32'h2, 32'h7);
    rd(`FCS_REG_RDATA, 32'hff, 32'hff);
    op(`FCS_OP_RESET, 32'h0, 32'h21);
    end_sim();
  end
endmodule
